// *** crs_pkg.sv ***
// Package of constants and types for the clock reference selector
package crs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int RATE_W = 18;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_VARSPD = 8'h04;
   localparam logic [7:0] OFS_START = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_FREQ = 8'h10;
   localparam logic [7:0] OFS_INTSTAT = 8'h14;
   localparam logic [7:0] OFS_INTMASK = 8'h18;
   localparam int CTRL_REF_LSB = 0;
   localparam int CTRL_PAL_BIT = 3;
   localparam int CTRL_GEN_BIT = 4;
   localparam int CTRL_GAIN_LSB = 5;
   localparam int CTRL_RATE_LSB = 8;
   localparam int CTRL_VARSPD_BIT = 11;
   localparam int CTRL_HOLD_BIT = 12;
   localparam int CTRL_PPF_LSB = 16;
   localparam int VS_SEMI_LSB = 0;
   localparam int VS_CENT_LSB = 8;
   localparam logic [2:0] GAIN_FASTEST = 3'h0;
   localparam logic [2:0] GAIN_SMOOTHEST = 3'h4;
   localparam logic [2:0] RATE_MAX_CODE = 3'h5;
   localparam logic [7:0] PILOT_PAL_HZ = 8'h32;
   localparam logic [7:0] PILOT_NTSC_HZ = 8'h3C;
   localparam logic [RATE_W-1:0] HZ_44K1 = 18'h0AC44;
   localparam logic [RATE_W-1:0] HZ_48K = 18'h0BB80;
   localparam logic [RATE_W-1:0] LIM1_MIN = 18'h09C40;
   localparam logic [RATE_W-1:0] LIM1_MAX = 18'h0C544;
   localparam logic [RATE_W-1:0] LIM2_MIN = 18'h13880;
   localparam logic [RATE_W-1:0] LIM2_MAX = 18'h18A88;
   localparam logic [RATE_W-1:0] LIM4_MIN = 18'h27100;
   localparam logic [RATE_W-1:0] LIM4_MAX = 18'h31510;
   localparam logic [15:0] CENT_COEF = 16'h0026;
   localparam int CLK_HZ = 50000000;
   localparam int FLASH_MS = 250;
   localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
   localparam int TACH_LOSS_MS = 100;
   localparam int TACH_LOSS_CYC = CLK_HZ / 1000 * TACH_LOSS_MS;
   localparam int FRAME_FPS = 30;
   localparam int FRAME_CYC = CLK_HZ / FRAME_FPS;
   localparam int INT_LOCK = 0;
   localparam int INT_UNLOCK = 1;
   localparam int INT_RANGE = 2;
   localparam int INT_W = 3;
   typedef enum logic [2:0] {
      REF_INTERNAL = 3'b000,
      REF_TIMECODE = 3'b001,
      REF_PILOT = 3'b010,
      REF_PULSE = 3'b011,
      REF_VIDEO = 3'b100,
      REF_DIGITAL = 3'b101
   } crs_ref_type;
endpackage

// *** crs_clock_reference_selector.sv ***
// Clock reference selection, varied rate and output clock generation
// Contract
// - Pilot tone frequency follows video format: PAL gives 50 Hz, NTSC 60 Hz.
// - Pilot tone gives clock timing only, never position information.
// - With pulse reference selected, locked is withheld until pulses arrive.
// - An invalid pulse reference makes the lock indicator flash.
// - Internal reference drives word clock and AES clock from the crystal.
// - Internal plus generate times all generated code outputs from crystal.
// - Variable speed offset is accepted whatever position source is chosen.
// - Variable speed offset changes only through the host port, not panel.
// - Offset in semitones plus cents; resulting word clock rate is readable.
// - Varied rate limited per base rate class: 1x, 2x and 4x windows.
// - Never output outside the limits; flag offsets that would exceed them.
// - Hold off: on reference loss return to exact nominal rate.
// - Hold on: on reference loss keep the last resolved rate.
// - Hold enable is kept in non-volatile storage across power cycles.
// - Time code resolve offers an adjustable servo loop gain.
// - Time code may serve as clock and position source at once.
// - Five servo gain settings, fastest first, fastest is the default.
`timescale 1ns/1ps
module crs_clock_reference_selector #(
   parameter int FLASH_CYCLES = crs_pkg::FLASH_CYC,
   parameter int TACH_LOSS_CYCLES = crs_pkg::TACH_LOSS_CYC,
   parameter int FRAME_CYCLES = crs_pkg::FRAME_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [crs_pkg::ADDR_W-1:0] regAddr,
   input wire logic [crs_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [crs_pkg::DATA_W-1:0] regRdData,
   input wire logic panelRefWr,
   input wire logic [2:0] panelRefSel,
   input wire logic panelHoldWr,
   input wire logic panelHoldVal,
   input wire logic nvHoldStored,
   output logic nvHoldWrite,
   output logic nvHoldData,
   input wire logic timecodePresentPin,
   input wire logic pilotPresentPin,
   input wire logic pulsePin,
   input wire logic videoPresentPin,
   input wire logic digitalPresentPin,
   input wire logic servoInRange,
   input wire logic [crs_pkg::RATE_W-1:0] servoRateHz,
   output logic [2:0] servoGain,
   output logic [7:0] pilotRefHz,
   output logic [crs_pkg::RATE_W-1:0] outRateHz,
   output logic wordClk,
   output logic aesFrameTick,
   output logic genFrameTick,
   output logic timecodePosEnable,
   output logic pulsePosEnable,
   output logic [23:0] pulseStartFrame,
   output logic [4:0] pulsesPerFrame,
   output logic lockedLed,
   output logic irq
);
   import crs_pkg::*;

   localparam int NPIN = 5;

   function automatic logic [RATE_W-1:0] nominalHz(input logic [2:0] code);
      logic [RATE_W-1:0] base;
      base = code[0] ? HZ_48K : HZ_44K1;
      case (code[2:1])
         2'b01: nominalHz = RATE_W'(base << 1);
         2'b10: nominalHz = RATE_W'(base << 2);
         default: nominalHz = base;
      endcase
   endfunction

   function automatic logic [RATE_W-1:0] limitHz(input logic [2:0] code,
                                                 input logic wantMax);
      case (code[2:1])
         2'b01: limitHz = wantMax ? LIM2_MAX : LIM2_MIN;
         2'b10: limitHz = wantMax ? LIM4_MAX : LIM4_MIN;
         default: limitHz = wantMax ? LIM1_MAX : LIM1_MIN;
      endcase
   endfunction

   function automatic logic validRef(input logic [2:0] code);
      validRef = (code <= 3'(REF_DIGITAL));
   endfunction

   crs_ref_type refSel_ff;
   logic palFormat_ff;
   logic posGenerate_ff;
   logic [2:0] gain_ff;
   logic [2:0] baseRate_ff;
   logic varSpdEn_ff;
   logic pitchHold_ff;
   logic [4:0] ppf_ff;
   logic signed [5:0] semis_ff;
   logic signed [7:0] cents_ff;
   logic [23:0] startFrame_ff;
   logic startValid_ff;
   logic nvLoad_ff;
   logic nvWrite_ff;
   logic [INT_W-1:0] intStat_ff;
   logic [INT_W-1:0] intMask_ff;
   logic [DATA_W-1:0] rdData_ff;
   logic [NPIN-1:0] sync1_ff;
   logic [NPIN-1:0] sync2_ff;
   logic [NPIN-1:0] sync3_ff;
   logic [NPIN-1:0] pinLevel_ff;
   logic pulseLast_ff;
   logic [31:0] pulseAge_ff;
   logic pulseSeen_ff;
   logic [RATE_W-1:0] heldRate_ff;
   logic [RATE_W-1:0] outRate_ff;
   logic outRange_ff;
   logic locked_ff;
   logic [31:0] flashCnt_ff;
   logic flash_ff;
   logic [31:0] clkAcc_ff;
   logic wordClk_ff;
   logic aesTick_ff;
   logic [31:0] frameCnt_ff;
   logic genTick_ff;

   logic ctrlWr;
   logic refPresent;
   logic refValid;
   logic lockNow;
   logic [RATE_W-1:0] nomRate;
   logic [RATE_W-1:0] minRate;
   logic [RATE_W-1:0] maxRate;
   logic signed [13:0] totalCents;
   logic signed [39:0] product;
   logic signed [21:0] variedRaw;
   logic [RATE_W-1:0] wantRate;
   logic wantOutOfRange;
   logic [RATE_W-1:0] nxt_outRate;
   logic [INT_W-1:0] intEvent;
   logic [32:0] accSum;

   assign ctrlWr = regWr && (regAddr == OFS_CTRL);

   // Reference selection: host or panel, illegal codes keep the old choice
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refSel_ff <= REF_INTERNAL;
      end else if (ctrlWr && validRef(regWrData[CTRL_REF_LSB+:3])) begin
         refSel_ff <= crs_ref_type'(regWrData[CTRL_REF_LSB+:3]);
      end else if (panelRefWr && validRef(panelRefSel)) begin
         refSel_ff <= crs_ref_type'(panelRefSel);
      end
   end

   // Configuration; the panel has no path into the offset registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         palFormat_ff <= 1'b0;
         posGenerate_ff <= 1'b0;
         gain_ff <= GAIN_FASTEST;
         baseRate_ff <= 3'h0;
         varSpdEn_ff <= 1'b0;
         ppf_ff <= 5'h0;
         semis_ff <= 6'sh00;
         cents_ff <= 8'sh00;
      end else begin
         if (ctrlWr) begin
            palFormat_ff <= regWrData[CTRL_PAL_BIT];
            posGenerate_ff <= regWrData[CTRL_GEN_BIT];
            // Out-of-range gain codes saturate at the smoothest setting
            if (regWrData[CTRL_GAIN_LSB+:3] > GAIN_SMOOTHEST) begin
               gain_ff <= GAIN_SMOOTHEST;
            end else begin
               gain_ff <= regWrData[CTRL_GAIN_LSB+:3];
            end
            if (regWrData[CTRL_RATE_LSB+:3] <= RATE_MAX_CODE) begin
               baseRate_ff <= regWrData[CTRL_RATE_LSB+:3];
            end
            varSpdEn_ff <= regWrData[CTRL_VARSPD_BIT];
            ppf_ff <= regWrData[CTRL_PPF_LSB+:5];
         end
         if (regWr && regAddr == OFS_VARSPD) begin
            semis_ff <= regWrData[VS_SEMI_LSB+:6];
            cents_ff <= regWrData[VS_CENT_LSB+:8];
         end
      end
   end

   // Start address; position from pulses is refused until one is given
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         startFrame_ff <= 24'h000000;
         startValid_ff <= 1'b0;
      end else if (regWr && regAddr == OFS_START) begin
         startFrame_ff <= regWrData[23:0];
         startValid_ff <= 1'b1;
      end
   end

   // Hold enable: restored from storage after reset, written back on every control or panel hold write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         nvLoad_ff <= 1'b1;
         pitchHold_ff <= 1'b0;
         nvWrite_ff <= 1'b0;
      end else begin
         nvLoad_ff <= 1'b0;
         nvWrite_ff <= 1'b0;
         if (nvLoad_ff) begin
            pitchHold_ff <= nvHoldStored;
         end else if (ctrlWr) begin
            pitchHold_ff <= regWrData[CTRL_HOLD_BIT];
            nvWrite_ff <= 1'b1;
         end else if (panelHoldWr) begin
            pitchHold_ff <= panelHoldVal;
            nvWrite_ff <= 1'b1;
         end
      end
   end

   // Pin synchronisers; a level is taken once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : gSync
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
               sync3_ff[gi] <= 1'b0;
               pinLevel_ff[gi] <= 1'b0;
            end else begin
               sync2_ff[gi] <= sync1_ff[gi];
               sync3_ff[gi] <= sync2_ff[gi];
               if (sync2_ff[gi] == sync3_ff[gi]) begin
                  pinLevel_ff[gi] <= sync3_ff[gi];
               end
               sync1_ff[gi] <= (gi == 0) ? timecodePresentPin :
                               (gi == 1) ? pilotPresentPin :
                               (gi == 2) ? pulsePin :
                               (gi == 3) ? videoPresentPin :
                               digitalPresentPin;
            end
         end
      end
   endgenerate

   // Pulse presence: any edge within the loss window counts as present
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pulseLast_ff <= 1'b0;
         pulseAge_ff <= 32'h00000000;
         pulseSeen_ff <= 1'b0;
      end else begin
         pulseLast_ff <= pinLevel_ff[2];
         if (pinLevel_ff[2] != pulseLast_ff) begin
            pulseAge_ff <= 32'h00000000;
            pulseSeen_ff <= 1'b1;
         end else if (pulseAge_ff >= 32'(TACH_LOSS_CYCLES - 1)) begin
            pulseSeen_ff <= 1'b0;
         end else begin
            pulseAge_ff <= pulseAge_ff + 32'h00000001;
         end
      end
   end

   always_comb begin
      case (refSel_ff)
         REF_INTERNAL: refPresent = 1'b1;
         REF_TIMECODE: refPresent = pinLevel_ff[0];
         REF_PILOT: refPresent = pinLevel_ff[1];
         REF_PULSE: refPresent = pulseSeen_ff;
         REF_VIDEO: refPresent = pinLevel_ff[3];
         REF_DIGITAL: refPresent = pinLevel_ff[4];
         default: refPresent = 1'b0;
      endcase
   end

   // A pulse reference also needs a pulses-per-frame figure to be usable
   assign refValid = refPresent &&
                     !(refSel_ff == REF_PULSE && ppf_ff == 5'h00);
   assign lockNow = refValid &&
                    (refSel_ff == REF_INTERNAL || servoInRange);

   // Varied rate: 2^(c/1200) taken as 1 + c*ln2/1200, close for small offsets
   assign nomRate = nominalHz(baseRate_ff);
   assign minRate = limitHz(baseRate_ff, 1'b0);
   assign maxRate = limitHz(baseRate_ff, 1'b1);
   // Wide enough for the full semitone and cent span without wrapping
   assign totalCents = 14'(14'(semis_ff) * 14'sd100) + 14'(cents_ff);
   assign product = 40'(signed'({1'b0, nomRate})) * 40'(totalCents) *
                    40'(signed'({1'b0, CENT_COEF}));
   assign variedRaw = 22'(signed'({2'b00, nomRate})) +
                      22'(product >>> 16);
   assign wantOutOfRange = varSpdEn_ff &&
                           (variedRaw < 22'(signed'({2'b00, minRate})) ||
                            variedRaw > 22'(signed'({2'b00, maxRate})));

   always_comb begin
      // Offset applies in any position mode, so no position term here
      if (!varSpdEn_ff) begin
         wantRate = nomRate;
      end else if (variedRaw < 22'(signed'({2'b00, minRate}))) begin
         wantRate = minRate;
      end else if (variedRaw > 22'(signed'({2'b00, maxRate}))) begin
         wantRate = maxRate;
      end else begin
         wantRate = variedRaw[RATE_W-1:0];
      end
      if (refSel_ff == REF_INTERNAL) begin
         nxt_outRate = wantRate;
      end else if (lockNow) begin
         if (servoRateHz < minRate) begin
            nxt_outRate = minRate;
         end else if (servoRateHz > maxRate) begin
            nxt_outRate = maxRate;
         end else begin
            nxt_outRate = servoRateHz;
         end
      end else if (pitchHold_ff) begin
         // A base rate change must not carry a held rate past the limits
         if (heldRate_ff < minRate) begin
            nxt_outRate = minRate;
         end else if (heldRate_ff > maxRate) begin
            nxt_outRate = maxRate;
         end else begin
            nxt_outRate = heldRate_ff;
         end
      end else begin
         nxt_outRate = nomRate;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         outRate_ff <= HZ_44K1;
         heldRate_ff <= HZ_44K1;
         outRange_ff <= 1'b0;
         locked_ff <= 1'b0;
      end else begin
         outRate_ff <= nxt_outRate;
         outRange_ff <= wantOutOfRange;
         locked_ff <= lockNow;
         // Held value is refreshed while resolved, and clamped when it lies outside the limits
         if (lockNow || heldRate_ff < minRate || heldRate_ff > maxRate) begin
            heldRate_ff <= nxt_outRate;
         end
      end
   end

   // Flash divider for the lock indicator
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flashCnt_ff <= 32'h00000000;
         flash_ff <= 1'b0;
      end else if (flashCnt_ff >= 32'(FLASH_CYCLES - 1)) begin
         flashCnt_ff <= 32'h00000000;
         flash_ff <= !flash_ff;
      end else begin
         flashCnt_ff <= flashCnt_ff + 32'h00000001;
      end
   end

   // Crystal phase accumulator: two steps per sample give a square wave
   assign accSum = 33'(clkAcc_ff) + 33'({outRate_ff, 1'b0});

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clkAcc_ff <= 32'h00000000;
         wordClk_ff <= 1'b0;
         aesTick_ff <= 1'b0;
      end else begin
         aesTick_ff <= 1'b0;
         if (accSum >= 33'(CLK_HZ)) begin
            clkAcc_ff <= 32'(accSum - 33'(CLK_HZ));
            wordClk_ff <= !wordClk_ff;
            aesTick_ff <= !wordClk_ff;
         end else begin
            clkAcc_ff <= 32'(accSum);
         end
      end
   end

   // Generated code frame timing from the crystal in internal generate mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         frameCnt_ff <= 32'h00000000;
         genTick_ff <= 1'b0;
      end else begin
         genTick_ff <= 1'b0;
         if (!(refSel_ff == REF_INTERNAL && posGenerate_ff)) begin
            frameCnt_ff <= 32'h00000000;
         end else if (frameCnt_ff >= 32'(FRAME_CYCLES - 1)) begin
            frameCnt_ff <= 32'h00000000;
            genTick_ff <= 1'b1;
         end else begin
            frameCnt_ff <= frameCnt_ff + 32'h00000001;
         end
      end
   end

   // Sticky events; a new event beats a simultaneous clear
   assign intEvent[INT_LOCK] = lockNow && !locked_ff;
   assign intEvent[INT_UNLOCK] = !lockNow && locked_ff;
   assign intEvent[INT_RANGE] = wantOutOfRange && !outRange_ff;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         intStat_ff <= '0;
         intMask_ff <= '0;
      end else begin
         if (regWr && regAddr == OFS_INTSTAT) begin
            intStat_ff <= (intStat_ff & ~regWrData[INT_W-1:0]) | intEvent;
         end else begin
            intStat_ff <= intStat_ff | intEvent;
         end
         if (regWr && regAddr == OFS_INTMASK) begin
            intMask_ff <= regWrData[INT_W-1:0];
         end
      end
   end

   // Register read; unmapped offsets read as zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdData_ff <= '0;
      end else if (regRd) begin
         case (regAddr)
            OFS_CTRL: rdData_ff <= {11'h000, ppf_ff, 3'h0, pitchHold_ff,
                                    varSpdEn_ff, baseRate_ff, gain_ff,
                                    posGenerate_ff, palFormat_ff, refSel_ff};
            OFS_VARSPD: rdData_ff <= {16'h0000, cents_ff, 2'h0, semis_ff};
            OFS_START: rdData_ff <= {7'h00, startValid_ff, startFrame_ff};
            OFS_STATUS: rdData_ff <= {16'h0000, pilotRefHz, refSel_ff,
                                      pulsePosEnable, refPresent,
                                      outRange_ff, lockedLed, locked_ff};
            OFS_FREQ: rdData_ff <= {14'h0000, outRate_ff};
            OFS_INTSTAT: rdData_ff <= {29'h00000000, intStat_ff};
            OFS_INTMASK: rdData_ff <= {29'h00000000, intMask_ff};
            default: rdData_ff <= '0;
         endcase
      end else begin
         rdData_ff <= '0;
      end
   end

   assign regRdData = rdData_ff;
   assign nvHoldWrite = nvWrite_ff;
   assign nvHoldData = pitchHold_ff;
   assign servoGain = gain_ff;
   assign pilotRefHz = palFormat_ff ? PILOT_PAL_HZ : PILOT_NTSC_HZ;
   assign outRateHz = outRate_ff;
   assign wordClk = wordClk_ff;
   assign aesFrameTick = aesTick_ff;
   assign genFrameTick = genTick_ff;
   // Pilot tone never enables a position path
   assign timecodePosEnable = !posGenerate_ff &&
                              pinLevel_ff[0];
   assign pulsePosEnable = !posGenerate_ff && startValid_ff &&
                           refSel_ff == REF_PULSE &&
                           refValid;
   assign pulseStartFrame = startFrame_ff;
   assign pulsesPerFrame = ppf_ff;
   assign lockedLed = locked_ff ? 1'b1 :
                      (!refValid ? flash_ff : 1'b0);
   assign irq = |(intStat_ff & intMask_ff);
endmodule

// *** crs_properties.sv ***
// Port checker for the clock reference selector
`timescale 1ns/1ps
module crs_properties
   import crs_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   input wire logic panelHoldWr,
   input wire logic panelHoldVal,
   input wire logic nvHoldWrite,
   input wire logic nvHoldData,
   input wire logic [2:0] servoGain,
   input wire logic [7:0] pilotRefHz,
   input wire logic [17:0] outRateHz,
   input wire logic wordClk,
   input wire logic aesFrameTick,
   input wire logic genFrameTick,
   input wire logic lockedLed,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_PILOT: assert property (regWr && regAddr == OFS_CTRL |=>
      pilotRefHz == ($past(regWrData[3]) ? PILOT_PAL_HZ : PILOT_NTSC_HZ))
      else $error("pilot frequency does not follow format");
   AST_RANGE: assert property (outRateHz inside {[LIM1_MIN:LIM1_MAX],
      [LIM2_MIN:LIM2_MAX], [LIM4_MIN:LIM4_MAX]})
      else $error("output rate outside limits");
   AST_GAIN: assert property (servoGain <= GAIN_SMOOTHEST)
      else $error("servo gain beyond five settings");
   AST_NVWR: assert property (panelHoldWr &&
      !(regWr && regAddr == OFS_CTRL) |=>
      nvHoldWrite && nvHoldData == $past(panelHoldVal))
      else $error("hold setting not stored");
   AST_AES: assert property (aesFrameTick == $rose(wordClk))
      else $error("aes tick not tied to word clock");
   AST_GEN: assert property (genFrameTick |=> !genFrameTick [*8])
      else $error("generated frame ticks too close");
   AST_FREQ: assert property (regRd && regAddr == OFS_FREQ |=>
      regRdData[17:0] == $past(outRateHz))
      else $error("frequency readback wrong");
   AST_IDLE: assert property (!regRd |=> regRdData == 32'h0)
      else $error("read data without read");
   cover property (irq);
   cover property ($rose(genFrameTick));
   cover property ($fell(lockedLed));
endmodule
bind crs_clock_reference_selector crs_properties crs_properties_inst (
   .clk, .reset, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
   .panelHoldWr, .panelHoldVal, .nvHoldWrite, .nvHoldData, .servoGain,
   .pilotRefHz, .outRateHz, .wordClk, .aesFrameTick, .genFrameTick,
   .lockedLed, .irq);

// *** crs_ref_model.sv ***
// Far-side transport model: tach pulse train that stops dead when halted
`timescale 1ns/1ps
module crs_ref_model #(
   parameter int HALF = 3
) (
   input wire logic clk,
   input wire logic pulseOn,
   output logic pulsePin
);
   int cnt = 0;
   initial pulsePin = 1'b0;
   // A stopped transport leaves the line where it was, no edges
   always @(posedge clk) begin
      if (pulseOn) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) pulsePin <= ~pulsePin;
      end
   end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the clock reference selector
`timescale 1ns/1ps
module tb_top;
   import crs_pkg::*;
   logic clk, reset, regWr, regRd, panelRefWr, panelHoldWr, panelHoldVal;
   logic timecodePresentPin, pilotPresentPin, pulsePin, videoPresentPin;
   logic digitalPresentPin, servoInRange, pulseOn, nvHoldWrite, nvHoldData;
   logic wordClk, aesFrameTick, genFrameTick, timecodePosEnable, irq;
   logic pulsePosEnable, lockedLed, nvHoldStored;
   logic [7:0] regAddr, pilotRefHz;
   logic [31:0] regWrData, regRdData, rdv;
   logic [2:0] panelRefSel, servoGain;
   logic [17:0] servoRateHz, outRateHz;
   logic [17:0] rowRate [6];
   logic [23:0] pulseStartFrame;
   logic [4:0] pulsesPerFrame;
   int err_count = 0;
   int checked = 0;
   int n;
   crs_clock_reference_selector #(.FLASH_CYCLES(4), .TACH_LOSS_CYCLES(50),
      .FRAME_CYCLES(20)) crs_clock_reference_selector_inst (.clk, .reset,
      .regAddr, .regWrData, .regWr, .regRd, .regRdData, .panelRefWr,
      .panelRefSel, .panelHoldWr, .panelHoldVal, .nvHoldStored,
      .nvHoldWrite, .nvHoldData, .timecodePresentPin, .pilotPresentPin,
      .pulsePin, .videoPresentPin, .digitalPresentPin, .servoInRange,
      .servoRateHz, .servoGain, .pilotRefHz, .outRateHz, .wordClk,
      .aesFrameTick, .genFrameTick, .timecodePosEnable, .pulsePosEnable,
      .pulseStartFrame, .pulsesPerFrame, .lockedLed, .irq);
   crs_ref_model crs_ref_model_inst (.clk, .pulseOn, .pulsePin);
   task automatic chk(input string nm, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdv = regRdData;
   endtask
   task automatic waitLock;
      n = 0;
      do rd(OFS_STATUS); while (rdv[0] !== 1'b1 && ++n < 40);
   endtask
   task automatic results;
      if (err_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #200000;
      err_count++;
      results;
   end
   initial begin
      {reset, regWr, regRd, regAddr, regWrData, panelRefWr, panelRefSel} = '0;
      reset = 1'b1;
      {panelHoldWr, panelHoldVal, timecodePresentPin, pilotPresentPin} = '0;
      {videoPresentPin, digitalPresentPin, servoInRange, pulseOn} = '0;
      nvHoldStored = 1'b0;
      servoRateHz = 18'h0AFC8;
      rowRate = '{HZ_44K1, HZ_48K, HZ_44K1 << 1, HZ_48K << 1, HZ_44K1 << 2,
         HZ_48K << 2};
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk("reset gain", GAIN_FASTEST, servoGain);
      rd(8'hFC);
      chk("unmapped", 32'h0, rdv);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CTRL, {21'h0, i[2:0], 4'h0, i[0], 3'h0});
         rd(OFS_FREQ);
         chk("nominal rate", rowRate[i], rdv[17:0]);
         chk("pilot hz", i[0] ? PILOT_PAL_HZ : PILOT_NTSC_HZ, pilotRefHz);
      end
      // Vary while generating: offset must not depend on position mode
      wr(OFS_INTMASK, 32'h4);
      wr(OFS_VARSPD, 32'h0C);
      wr(OFS_CTRL, 32'h810);
      rd(OFS_FREQ);
      chk("vary high", LIM1_MAX, rdv[17:0]);
      chk("range irq", 1, irq);
      rd(OFS_STATUS);
      chk("range flag", 1, rdv[2]);
      n = 0;
      repeat (40) @(posedge clk) n += genFrameTick;
      chk("gen ticks", 2, n);
      wr(OFS_INTSTAT, 32'h4);
      #1 chk("irq cleared", 0, irq);
      wr(OFS_VARSPD, 32'h34);
      rd(OFS_FREQ);
      chk("vary low", LIM1_MIN, rdv[17:0]);
      wr(OFS_VARSPD, 32'h0);
      servoInRange <= 1'b1;
      wr(OFS_CTRL, 32'h3);
      n = 0;
      repeat (16) @(posedge clk) n += lockedLed;
      chk("flashing", 1, n > 2 && n < 14);
      wr(OFS_CTRL, 32'h50003);
      wr(OFS_START, 32'h100);
      rd(OFS_STATUS);
      chk("no pulses", 0, rdv[0]);
      chk("start frame", 32'h100, pulseStartFrame);
      chk("ppf", 5, pulsesPerFrame);
      pulseOn <= 1'b1;
      waitLock;
      chk("locked", 1, rdv[0]);
      chk("pulse pos", 1, pulsePosEnable);
      chk("ref field", 3, rdv[7:5]);
      chk("masked irq", 0, irq);
      servoInRange <= 1'b0;
      repeat (4) rd(OFS_FREQ);
      chk("nominal on loss", HZ_44K1, rdv[17:0]);
      wr(OFS_CTRL, 32'h51003);
      servoInRange <= 1'b1;
      waitLock;
      pulseOn <= 1'b0;
      repeat (80) @(posedge clk);
      rd(OFS_FREQ);
      chk("held rate", 18'h0AFC8, rdv[17:0]);
      wr(OFS_CTRL, 32'h51203);
      rd(OFS_FREQ);
      chk("held clamp", LIM2_MIN, rdv[17:0]);
      @(posedge clk);
      panelHoldWr <= 1'b1;
      panelRefWr <= 1'b1;
      panelRefSel <= 3'h2;
      @(posedge clk);
      panelHoldWr <= 1'b0;
      panelRefWr <= 1'b0;
      #1 chk("nv write", 1, nvHoldWrite);
      chk("nv data", 0, nvHoldData);
      rd(OFS_STATUS);
      chk("panel ref", 2, rdv[7:5]);
      chk("pilot no pos", 0, pulsePosEnable);
      wr(OFS_CTRL, 32'hE1);
      timecodePresentPin <= 1'b1;
      repeat (8) @(posedge clk);
      chk("gain sat", GAIN_SMOOTHEST, servoGain);
      chk("tc pos", 1, timecodePosEnable);
      wr(OFS_CTRL, 32'hE6);
      rd(OFS_STATUS);
      chk("bad ref kept", 1, rdv[7:5]);
      wr(OFS_CTRL, 32'h0);
      // 44100 Hz from a 50 MHz crystal: 1133 or 1134 cycles a period
      @(posedge clk iff aesFrameTick);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!aesFrameTick && n < 2000);
      chk("word clk period", 1, n == 1133 || n == 1134);
      nvHoldStored <= 1'b1;
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1 chk("nv restore", 1, nvHoldData);
      chk("no nv write", 0, nvHoldWrite);
      results;
   end
endmodule
